// ### rtl/dvr_pkg.sv
// Constants and types shared by the dual-rail regulator register bank
package dvr_pkg;
   // ==========================================
   // Register offsets
   localparam logic [7:0] DVR_OFS_GFX_BOOT = 8'h3f;
   localparam logic [7:0] DVR_OFS_CORE_TEMP = 8'h40;
   localparam logic [7:0] DVR_OFS_GFX_TEMP = 8'h41;
   localparam logic [7:0] DVR_OFS_CORE_TRIM = 8'h42;
   localparam logic [7:0] DVR_OFS_GFX_TRIM = 8'h43;
   localparam logic [7:0] DVR_OFS_GFX_BAL = 8'h44;
   localparam logic [7:0] DVR_OFS_PART_ID = 8'hb2;
   // ==========================================
   // Reset values
   localparam logic [7:0] DVR_RST_GFX_BOOT = 8'h00;
   localparam logic [7:0] DVR_RST_TEMP = 8'h00;
   localparam logic [7:0] DVR_RST_TRIM = 8'h63;
   localparam logic [7:0] DVR_RST_GFX_BAL = 8'h40;
   // ==========================================
   // Field layout
   localparam int DVR_TRIM_FAST_LSB = 4;
   localparam int DVR_TRIM_SLOW_LSB = 0;
   localparam int DVR_BAL_GAIN_LSB = 4;
   localparam int DVR_BAL_OFS_LSB = 0;
   localparam logic [7:0] DVR_BAL_MASK = 8'h77;
   localparam logic [7:0] DVR_BOOT_FROM_STRAP = 8'h00;
   // ==========================================
   // Temperature codes, one count per degree
   localparam logic [7:0] DVR_TEMP_MAX = 8'h96;
   localparam logic [7:0] DVR_ALERT_ON = 8'h67;
   localparam logic [7:0] DVR_ALERT_OFF = 8'h64;
   localparam logic [7:0] DVR_HOT_ON = 8'h6a;
   localparam logic [7:0] DVR_HOT_OFF = 8'h67;
   // ==========================================
   // Bus addressing
   localparam logic [6:0] DVR_DEFAULT_ADDR = 7'h44;
   localparam logic [3:0] DVR_BYTE_BITS = 4'h8;
   // ==========================================
   // Serial slave states
   typedef enum logic [8:0] {
      DVR_IDLE = 9'b000000001,
      DVR_ADDR = 9'b000000010,
      DVR_ADDR_ACK = 9'b000000100,
      DVR_CMD = 9'b000001000,
      DVR_CMD_ACK = 9'b000010000,
      DVR_WDATA = 9'b000100000,
      DVR_WDATA_ACK = 9'b001000000,
      DVR_RDATA = 9'b010000000,
      DVR_RDATA_ACK = 9'b100000000
   } dvr_state_t;
endpackage

// ### rtl/dvr_hyst.sv
// Threshold comparator with hysteresis for one temperature indication
`timescale 1ns/1ps
module dvr_hyst
   import dvr_pkg::*;
#(
   parameter logic [7:0] ON_LEVEL = 8'h00,
   parameter logic [7:0] OFF_LEVEL = 8'h00
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [7:0] value,
   output logic flag_ff
);
   // ==========================================
   // Set at or above ON_LEVEL, clear at or below OFF_LEVEL
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         flag_ff <= 1'b0;
      end else if (ce) begin
         if (value >= ON_LEVEL) begin
            flag_ff <= 1'b1;
         end else if (value <= OFF_LEVEL) begin
            flag_ff <= 1'b0;
         end
      end
   end
endmodule

// ### rtl/dvr_regs.sv
// Serial-bus register bank tail of the dual-rail regulator controller
`timescale 1ns/1ps
module dvr_regs
   import dvr_pkg::*;
#(
   parameter logic [7:0] PART_ID = 8'ha5 // Arbitrary identifier value
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic [6:0] bus_addr_strap,
   input wire logic [7:0] gfx_boot_strap_code,
   input wire logic gfx_rail_enable,
   input wire logic [7:0] core_temp_sense_pin,
   input wire logic core_temp_valid,
   input wire logic [7:0] gfx_temp_sense_pin,
   input wire logic gfx_temp_valid,
   output logic [7:0] gfx_boot_voltage,
   output logic gfx_boot_from_reg,
   output logic [3:0] core_fast_up_overshoot_trim,
   output logic [3:0] core_slow_up_overshoot_trim,
   output logic [3:0] gfx_fast_up_overshoot_trim,
   output logic [3:0] gfx_slow_up_overshoot_trim,
   output logic [2:0] gfx_third_phase_gain,
   output logic [2:0] gfx_third_phase_offset,
   output logic attention_out,
   output logic attention_oe,
   output logic overtemp_line_out,
   output logic overtemp_line_oe
);
   // ==========================================
   // Declarations
   dvr_state_t state_ff;
   logic scl_q_ff, sda_q_ff;
   logic [3:0] cnt_ff;
   logic [7:0] shift_ff, tx_ff, ptr_ff;
   logic rw_ff, oe_ff;
   logic wr_en_ff;
   logic [7:0] wr_addr_ff, wr_data_ff;
   logic [7:0] rd_data;
   logic scl_rise, scl_fall, bus_start, bus_stop;
   logic [6:0] dev_addr_ff;
   logic strap_done_ff;
   logic [7:0] gfx_boot_ff, core_trim_ff, gfx_trim_ff, gfx_bal_ff;
   logic [7:0] core_temp_ff, gfx_temp_ff, hottest;
   logic [7:0] boot_code_ff;
   logic boot_from_reg_ff, rail_en_q_ff;
   logic alert_flag, hot_flag;

   function automatic logic [7:0] dvr_clamp(input logic [7:0] v);
      dvr_clamp = (v > DVR_TEMP_MAX) ? DVR_TEMP_MAX : v;
   endfunction

   // ==========================================
   // Bus line edges and conditions
   assign scl_rise = scl_in & ~scl_q_ff;
   assign scl_fall = ~scl_in & scl_q_ff;
   assign bus_start = scl_in & scl_q_ff & sda_q_ff & ~sda_in;
   assign bus_stop = scl_in & scl_q_ff & ~sda_q_ff & sda_in;
   assign sda_out = 1'b0;
   assign sda_oe = oe_ff;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         scl_q_ff <= 1'b1;
         sda_q_ff <= 1'b1;
      end else if (ce) begin
         scl_q_ff <= scl_in;
         sda_q_ff <= sda_in;
      end
   end

   // ==========================================
   // Address strap caught after reset release
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         dev_addr_ff <= DVR_DEFAULT_ADDR;
         strap_done_ff <= 1'b0;
      end else if (ce && !strap_done_ff) begin
         dev_addr_ff <= bus_addr_strap;
         strap_done_ff <= 1'b1;
      end
   end

   // ==========================================
   // Serial slave: byte write and byte read with auto-increment
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_ff <= DVR_IDLE;
         cnt_ff <= 4'h0;
         shift_ff <= 8'h00;
         tx_ff <= 8'h00;
         ptr_ff <= 8'h00;
         rw_ff <= 1'b0;
         oe_ff <= 1'b0;
         wr_en_ff <= 1'b0;
         wr_addr_ff <= 8'h00;
         wr_data_ff <= 8'h00;
      end else if (ce) begin
         wr_en_ff <= 1'b0;
         if (bus_start) begin
            state_ff <= DVR_ADDR;
            cnt_ff <= 4'h0;
            oe_ff <= 1'b0;
         end else if (bus_stop) begin
            state_ff <= DVR_IDLE;
            oe_ff <= 1'b0;
         end else if (scl_rise && state_ff != DVR_IDLE) begin
            shift_ff <= {shift_ff[6:0], sda_in};
            cnt_ff <= 4'(cnt_ff + 4'h1);
            if (state_ff == DVR_RDATA_ACK && !sda_in) begin
               ptr_ff <= 8'(ptr_ff + 8'h01);
            end
         end else if (scl_fall) begin
            case (state_ff)
               DVR_ADDR: begin
                  if (cnt_ff == DVR_BYTE_BITS) begin
                     if (shift_ff[7:1] == dev_addr_ff) begin
                        rw_ff <= shift_ff[0];
                        oe_ff <= 1'b1;
                        state_ff <= DVR_ADDR_ACK;
                     end else begin
                        state_ff <= DVR_IDLE;
                     end
                  end
               end
               DVR_ADDR_ACK: begin
                  cnt_ff <= 4'h0;
                  if (rw_ff) begin
                     tx_ff <= rd_data;
                     oe_ff <= ~rd_data[7];
                     state_ff <= DVR_RDATA;
                  end else begin
                     oe_ff <= 1'b0;
                     state_ff <= DVR_CMD;
                  end
               end
               DVR_CMD: begin
                  if (cnt_ff == DVR_BYTE_BITS) begin
                     ptr_ff <= shift_ff;
                     oe_ff <= 1'b1;
                     state_ff <= DVR_CMD_ACK;
                  end
               end
               DVR_CMD_ACK: begin
                  oe_ff <= 1'b0;
                  cnt_ff <= 4'h0;
                  state_ff <= DVR_WDATA;
               end
               DVR_WDATA: begin
                  if (cnt_ff == DVR_BYTE_BITS) begin
                     wr_en_ff <= 1'b1;
                     wr_addr_ff <= ptr_ff;
                     wr_data_ff <= shift_ff;
                     oe_ff <= 1'b1;
                     state_ff <= DVR_WDATA_ACK;
                  end
               end
               DVR_WDATA_ACK: begin
                  oe_ff <= 1'b0;
                  cnt_ff <= 4'h0;
                  ptr_ff <= 8'(ptr_ff + 8'h01);
                  state_ff <= DVR_WDATA;
               end
               DVR_RDATA: begin
                  if (cnt_ff == DVR_BYTE_BITS) begin
                     oe_ff <= 1'b0;
                     state_ff <= DVR_RDATA_ACK;
                  end else begin
                     tx_ff <= {tx_ff[6:0], 1'b0};
                     oe_ff <= ~tx_ff[6];
                  end
               end
               DVR_RDATA_ACK: begin
                  cnt_ff <= 4'h0;
                  if (!shift_ff[0]) begin
                     tx_ff <= rd_data;
                     oe_ff <= ~rd_data[7];
                     state_ff <= DVR_RDATA;
                  end else begin
                     oe_ff <= 1'b0;
                     state_ff <= DVR_IDLE;
                  end
               end
               default: begin
                  oe_ff <= 1'b0;
                  state_ff <= DVR_IDLE;
               end
            endcase
         end
      end
   end

   // ==========================================
   // Read multiplexer; unmapped offsets read zero
   always_comb begin
      case (ptr_ff)
         DVR_OFS_GFX_BOOT: rd_data = gfx_boot_ff;
         DVR_OFS_CORE_TEMP: rd_data = core_temp_ff;
         DVR_OFS_GFX_TEMP: rd_data = gfx_temp_ff;
         DVR_OFS_CORE_TRIM: rd_data = core_trim_ff;
         DVR_OFS_GFX_TRIM: rd_data = gfx_trim_ff;
         DVR_OFS_GFX_BAL: rd_data = gfx_bal_ff & DVR_BAL_MASK;
         DVR_OFS_PART_ID: rd_data = PART_ID;
         default: rd_data = 8'h00;
      endcase
   end

   // ==========================================
   // Writable registers; read-only offsets have no write path
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         gfx_boot_ff <= DVR_RST_GFX_BOOT;
         core_trim_ff <= DVR_RST_TRIM;
         gfx_trim_ff <= DVR_RST_TRIM;
         gfx_bal_ff <= DVR_RST_GFX_BAL;
      end else if (ce && wr_en_ff) begin
         case (wr_addr_ff)
            DVR_OFS_GFX_BOOT: gfx_boot_ff <= wr_data_ff;
            DVR_OFS_CORE_TRIM: core_trim_ff <= wr_data_ff;
            DVR_OFS_GFX_TRIM: gfx_trim_ff <= wr_data_ff;
            DVR_OFS_GFX_BAL: gfx_bal_ff <= wr_data_ff & DVR_BAL_MASK;
            default: ;
         endcase
      end
   end

   assign core_fast_up_overshoot_trim = core_trim_ff[DVR_TRIM_FAST_LSB +: 4];
   assign core_slow_up_overshoot_trim = core_trim_ff[DVR_TRIM_SLOW_LSB +: 4];
   assign gfx_fast_up_overshoot_trim = gfx_trim_ff[DVR_TRIM_FAST_LSB +: 4];
   assign gfx_slow_up_overshoot_trim = gfx_trim_ff[DVR_TRIM_SLOW_LSB +: 4];
   assign gfx_third_phase_gain = gfx_bal_ff[DVR_BAL_GAIN_LSB +: 3];
   assign gfx_third_phase_offset = gfx_bal_ff[DVR_BAL_OFS_LSB +: 3];

   // ==========================================
   // Temperature readings, capped
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         core_temp_ff <= DVR_RST_TEMP;
         gfx_temp_ff <= DVR_RST_TEMP;
      end else if (ce) begin
         if (core_temp_valid) begin
            core_temp_ff <= dvr_clamp(core_temp_sense_pin);
         end
         if (gfx_temp_valid) begin
            gfx_temp_ff <= dvr_clamp(gfx_temp_sense_pin);
         end
      end
   end

   // ==========================================
   // Boot target latched at the rail enable rising edge
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rail_en_q_ff <= 1'b0;
         boot_code_ff <= DVR_BOOT_FROM_STRAP;
         boot_from_reg_ff <= 1'b0;
      end else if (ce) begin
         rail_en_q_ff <= gfx_rail_enable;
         if (gfx_rail_enable && !rail_en_q_ff) begin
            if (gfx_boot_ff != DVR_BOOT_FROM_STRAP && dev_addr_ff == DVR_DEFAULT_ADDR) begin
               boot_code_ff <= gfx_boot_ff;
               boot_from_reg_ff <= 1'b1;
            end else begin
               boot_code_ff <= gfx_boot_strap_code;
               boot_from_reg_ff <= 1'b0;
            end
         end
      end
   end

   assign gfx_boot_voltage = boot_code_ff;
   assign gfx_boot_from_reg = boot_from_reg_ff;

   // ==========================================
   // Thermal indications from the hotter rail
   assign hottest = (core_temp_ff > gfx_temp_ff) ? core_temp_ff : gfx_temp_ff;

   dvr_hyst #(.ON_LEVEL(DVR_ALERT_ON), .OFF_LEVEL(DVR_ALERT_OFF)) u_alert (
      .sys_clk(sys_clk),
      .rst(rst),
      .ce(ce),
      .value(hottest),
      .flag_ff(alert_flag)
   );

   dvr_hyst #(.ON_LEVEL(DVR_HOT_ON), .OFF_LEVEL(DVR_HOT_OFF)) u_hot (
      .sys_clk(sys_clk),
      .rst(rst),
      .ce(ce),
      .value(hottest),
      .flag_ff(hot_flag)
   );

   assign attention_out = 1'b0;
   assign attention_oe = alert_flag;
   assign overtemp_line_out = 1'b0;
   assign overtemp_line_oe = hot_flag;
endmodule

// ### test/dvr_sva.sv
// Port checks for the regulator register bank
`timescale 1ns/1ps
module dvr_sva
   import dvr_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [7:0] gfx_boot_strap_code,
   input wire logic gfx_rail_enable,
   input wire logic [7:0] core_temp_sense_pin,
   input wire logic core_temp_valid,
   input wire logic [7:0] gfx_temp_sense_pin,
   input wire logic gfx_temp_valid,
   input wire logic [7:0] gfx_boot_voltage,
   input wire logic gfx_boot_from_reg,
   input wire logic attention_oe,
   input wire logic overtemp_line_oe
);
   // ====================
   // Assertions
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   wire logic both_new = ce && core_temp_valid && gfx_temp_valid;
   a_boot_only_rise: assert property ($changed(gfx_boot_voltage)
      || $changed(gfx_boot_from_reg) |-> $past(gfx_rail_enable) && !$past(gfx_rail_enable, 2))
      else $error("boot target changed without a rail enable rise");
   a_boot_strap_use: assert property (ce && gfx_rail_enable && !$past(gfx_rail_enable)
      |=> gfx_boot_from_reg || gfx_boot_voltage == $past(gfx_boot_strap_code))
      else $error("strapped boot code not taken");
   a_boot_reg_nonzero: assert property (gfx_boot_from_reg
      |-> gfx_boot_voltage != DVR_BOOT_FROM_STRAP)
      else $error("zero boot code marked as register value");
   a_att_on_level: assert property (ce && core_temp_valid
      && core_temp_sense_pin >= DVR_ALERT_ON |-> ##2 attention_oe)
      else $error("attention not raised at its level");
   a_att_off_level: assert property (both_new && core_temp_sense_pin <= DVR_ALERT_OFF
      && gfx_temp_sense_pin <= DVR_ALERT_OFF |-> ##2 !attention_oe)
      else $error("attention not released at its level");
   a_hot_on_level: assert property (ce && gfx_temp_valid
      && gfx_temp_sense_pin >= DVR_HOT_ON |-> ##2 overtemp_line_oe)
      else $error("overtemp not raised at its level");
   a_hot_off_level: assert property (both_new && core_temp_sense_pin <= DVR_HOT_OFF
      && gfx_temp_sense_pin <= DVR_HOT_OFF |-> ##2 !overtemp_line_oe)
      else $error("overtemp not released at its level");
   a_hot_needs_att: assert property (overtemp_line_oe |-> attention_oe)
      else $error("overtemp active without attention");
endmodule

bind dvr_regs dvr_sva u_sva (.sys_clk(sys_clk), .rst(rst), .ce(ce),
   .gfx_boot_strap_code(gfx_boot_strap_code), .gfx_rail_enable(gfx_rail_enable),
   .core_temp_sense_pin(core_temp_sense_pin), .core_temp_valid(core_temp_valid),
   .gfx_temp_sense_pin(gfx_temp_sense_pin), .gfx_temp_valid(gfx_temp_valid),
   .gfx_boot_voltage(gfx_boot_voltage), .gfx_boot_from_reg(gfx_boot_from_reg),
   .attention_oe(attention_oe), .overtemp_line_oe(overtemp_line_oe));

// ### test/dvr_host.sv
// Bus host model for the serial register port
`timescale 1ns/1ps
module dvr_host (
   input wire logic sys_clk,
   input wire logic sda,
   output logic scl,
   output logic sda_low
);
   // ====================
   // Bit and byte cycles
   logic nak;
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
      nak = 1'b0;
   end
   task automatic wt();
      repeat (3) @(negedge sys_clk);
   endtask
   task automatic cyc(input logic b, output logic r);
      sda_low = !b;
      wt();
      scl = 1'b1;
      wt();
      r = sda;
      scl = 1'b0;
      wt();
   endtask
   // Also serves as repeated start from mid-frame
   task automatic start();
      sda_low = 1'b0;
      wt();
      scl = 1'b1;
      wt();
      sda_low = 1'b1;
      wt();
      scl = 1'b0;
      wt();
   endtask
   task automatic stop();
      sda_low = 1'b1;
      wt();
      scl = 1'b1;
      wt();
      sda_low = 1'b0;
      wt();
   endtask
   task automatic xb(input logic [7:0] d, input logic rd, output logic [7:0] q);
      logic r;
      for (int i = 7; i >= 0; i--) cyc(d[i], q[i]);
      cyc(1'b1, r);
      if (r && !rd) nak = 1'b1;
   endtask
   task automatic reg_wr(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      start();
      xb({dev, 1'b0}, 1'b0, q);
      xb(a, 1'b0, q);
      xb(d, 1'b0, q);
      stop();
   endtask
   task automatic reg_rd(input logic [6:0] dev, input logic [7:0] a, output logic [7:0] q);
      start();
      xb({dev, 1'b0}, 1'b0, q);
      xb(a, 1'b0, q);
      start();
      xb({dev, 1'b1}, 1'b0, q);
      xb(8'hff, 1'b1, q);
      stop();
   endtask
endmodule

// ### test/testbench.sv
// Self-checking bench for the regulator register bank
`timescale 1ns/1ps
module testbench;
   import dvr_pkg::*;
   localparam logic [7:0] ID = 8'h5a; // Arbitrary identifier value
   localparam logic [7:0] OFS [7] = '{8'h3f, 8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'hb2};
   localparam logic [7:0] RSV [7] = '{8'h00, 8'h00, 8'h00, 8'h63, 8'h63, 8'h40, ID};
   localparam logic [7:0] HT [8] = '{8'h66, 8'h67, 8'h65, 8'h64, 8'h6a, 8'h69, 8'h67, 8'h97};
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic en = 1'b0;
   logic ce = 1'b1;
   logic [6:0] sa = DVR_DEFAULT_ADDR;
   logic tv = 1'b0;
   logic [7:0] strap = 8'h00;
   logic [7:0] ct = 8'h00;
   logic [7:0] gt = 8'h00;
   logic [7:0] q, d, e, a;
   logic att = 1'b0;
   logic hot = 1'b0;
   wire logic scl, low, oe, src, ao, ho;
   wire logic so, ato, hto;
   wire logic [7:0] boot;
   wire logic [3:0] cf, cs, gf, gs;
   wire logic [2:0] gg, go;
   wire logic sda = !(oe || low);
   int err_count = 0;
   int total_checks = 0;
   int cycles = 0;
   int seed = 80554;
   always #2.5 sys_clk = !sys_clk;
   dvr_host host (.sys_clk(sys_clk), .sda(sda), .scl(scl), .sda_low(low));
   dvr_regs #(.PART_ID(ID)) dut (.sys_clk(sys_clk), .rst(rst), .ce(ce), .scl_in(scl),
      .sda_in(sda), .sda_out(so), .sda_oe(oe), .bus_addr_strap(sa),
      .gfx_boot_strap_code(strap), .gfx_rail_enable(en), .core_temp_sense_pin(ct),
      .core_temp_valid(tv), .gfx_temp_sense_pin(gt), .gfx_temp_valid(tv),
      .gfx_boot_voltage(boot), .gfx_boot_from_reg(src), .core_fast_up_overshoot_trim(cf),
      .core_slow_up_overshoot_trim(cs), .gfx_fast_up_overshoot_trim(gf),
      .gfx_slow_up_overshoot_trim(gs), .gfx_third_phase_gain(gg), .gfx_third_phase_offset(go),
      .attention_out(ato), .attention_oe(ao), .overtemp_line_out(hto), .overtemp_line_oe(ho));
   // ====================
   // Helpers
   task automatic test_done();
      if (err_count == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 90000) begin
         err_count++;
         test_done();
      end
   end
   task automatic chk(input string n, input logic [7:0] x, input logic [7:0] s);
      total_checks++;
      if (s !== x) begin
         $display("unexpected %s expected %h seen %h", n, x, s);
         err_count++;
      end
   endtask
   function automatic logic [7:0] cap(input logic [7:0] v);
      return (v > DVR_TEMP_MAX) ? DVR_TEMP_MAX : v;
   endfunction
   function automatic logic hy(input logic s, input logic [7:0] v, input logic [7:0] on,
      input logic [7:0] off);
      if (v >= on) return 1'b1;
      if (v <= off) return 1'b0;
      return s;
   endfunction
   task automatic temp(input logic [7:0] c, input logic [7:0] g);
      logic [7:0] h;
      ct = c;
      gt = g;
      tv = 1'b1;
      @(negedge sys_clk);
      tv = 1'b0;
      repeat (3) @(negedge sys_clk);
      h = (cap(c) > cap(g)) ? cap(c) : cap(g);
      att = hy(att, h, DVR_ALERT_ON, DVR_ALERT_OFF);
      hot = hy(hot, h, DVR_HOT_ON, DVR_HOT_OFF);
      chk("attention", {7'h00, att}, {7'h00, ao});
      chk("overtemp", {7'h00, hot}, {7'h00, ho});
      host.reg_rd(DVR_DEFAULT_ADDR, DVR_OFS_CORE_TEMP, q);
      chk("core temp", cap(c), q);
      host.reg_rd(DVR_DEFAULT_ADDR, DVR_OFS_GFX_TEMP, q);
      chk("gfx temp", cap(g), q);
   endtask
   task automatic boot_chk(input logic [7:0] x, input logic r);
      en = 1'b1;
      repeat (3) @(negedge sys_clk);
      chk("boot voltage", x, boot);
      chk("boot source", {7'h00, r}, {7'h00, src});
   endtask
   // ====================
   // Main sequence
   initial begin
      strap = 8'($random(seed));
      repeat (8) @(negedge sys_clk);
      rst = 1'b0;
      repeat (4) @(negedge sys_clk);
      chk("port trims", 8'h63, {cf, cs});
      chk("port balance", 8'h40, {1'b0, gg, 1'b0, go});
      chk("drive levels", 8'h00, {5'h00, so, ato, hto});
      for (int i = 0; i < 7; i++) begin
         host.reg_rd(DVR_DEFAULT_ADDR, OFS[i], q);
         chk("reset value", RSV[i], q);
      end
      for (int i = 0; i < 8; i++) begin
         d = (i == 0) ? 8'hff : 8'($random(seed));
         host.reg_wr(DVR_DEFAULT_ADDR, OFS[3 + i % 2], d);
         host.reg_rd(DVR_DEFAULT_ADDR, OFS[3 + i % 2], q);
         chk("trim readback", d, q);
         chk("trim port", d, (i % 2 == 0) ? {cf, cs} : {gf, gs});
         e = {d[7], 3'(i), d[3], 3'(7 - i)};
         host.reg_wr(DVR_DEFAULT_ADDR, DVR_OFS_GFX_BAL, e);
         host.reg_rd(DVR_DEFAULT_ADDR, DVR_OFS_GFX_BAL, q);
         chk("balance readback", e & DVR_BAL_MASK, q);
         chk("balance port", e & DVR_BAL_MASK, {1'b0, gg, 1'b0, go});
      end
      for (int i = 0; i < 4; i++) begin
         a = (i == 3) ? 8'h50 : OFS[(i == 2) ? 6 : i + 1];
         host.reg_wr(DVR_DEFAULT_ADDR, a, 8'h5c);
         host.reg_rd(DVR_DEFAULT_ADDR, a, q);
         chk("read-only", (i == 3) ? 8'h00 : RSV[(i == 2) ? 6 : i + 1], q);
      end
      chk("bus ack", 8'h00, {7'h00, host.nak});
      host.reg_wr(DVR_DEFAULT_ADDR ^ 7'h01, DVR_OFS_CORE_TRIM, 8'h11);
      chk("foreign address", 8'h01, {7'h00, host.nak});
      for (int i = 0; i < 16; i++) begin
         if (i < 8) temp(HT[i], 8'h00);
         else temp(8'($random(seed)), 8'($random(seed)));
      end
      boot_chk(strap, 1'b0);
      en = 1'b0;
      d = 8'($random(seed)) | 8'h01;
      host.reg_wr(DVR_DEFAULT_ADDR, DVR_OFS_GFX_BOOT, d);
      boot_chk(d, 1'b1);
      host.reg_wr(DVR_DEFAULT_ADDR, DVR_OFS_GFX_BOOT, ~d);
      chk("boot hold", d, boot);
      host.reg_rd(DVR_DEFAULT_ADDR, DVR_OFS_GFX_BOOT, q);
      chk("boot readback", ~d, q);
      en = 1'b0;
      host.reg_wr(DVR_DEFAULT_ADDR, DVR_OFS_GFX_BOOT, 8'h00);
      boot_chk(strap, 1'b0);
      // Second reset with a non-default address strap
      en = 1'b0;
      sa = DVR_DEFAULT_ADDR ^ 7'h02;
      rst = 1'b1;
      repeat (2) @(negedge sys_clk);
      rst = 1'b0;
      repeat (4) @(negedge sys_clk);
      chk("reset boot", 8'h00, boot);
      chk("reset trims", 8'h63, {gf, gs});
      // Clock enable low must freeze the temperature capture
      ce = 1'b0;
      ct = 8'h80;
      tv = 1'b1;
      repeat (2) @(negedge sys_clk);
      tv = 1'b0;
      ce = 1'b1;
      host.reg_rd(sa, DVR_OFS_CORE_TEMP, q);
      chk("frozen temp", 8'h00, q);
      chk("frozen attention", 8'h00, {7'h00, ao});
      host.reg_wr(sa, DVR_OFS_GFX_BOOT, d);
      host.reg_rd(sa, DVR_OFS_GFX_BOOT, q);
      chk("strapped address boot", d, q);
      boot_chk(strap, 1'b0);
      test_done();
   end
endmodule
